//--- verilog/anr_defines.svh
// Offsets, field positions, reset values for the negotiation register bank.
// Assumes 5-bit management register addresses and 16-bit register data.
// How it works
// R01: Registers 0,1,4,5,6 present; 7 with next page
// R02: Enable set: manual speed and duplex ignored
// R03: Restart bit reads one until negotiation done
// R04: Writing restart one starts negotiation; completion clears
// R05: Restart self-clears; writing zero does nothing
// R06: Complete bit zero when disabled or unable
// R07: Complete bit set on successful negotiation
// R08: Remote fault sticky until status read or reset
// R09: Advertisement resets to selector, ack zero, abilities
// R10: Partner ability read-only, mirrors last code word
// R11: Expansion register read-only, writes ignored
// R12: Expansion bit 0: partner can negotiate
// R13: Expansion bit 1: new code word stored
// R14: Reading expansion clears page received bit
// R15: Expansion bit 2: local next page support
// R16: Expansion bit 3: partner next page support
// R17: Wait expiry with ready count not one: fault
// R18: Reading expansion clears parallel detect fault
// R19: Next page transmit register resets to 2001h
// R20: Next page write sets page loaded flag
// R21: Without management, advertised vector from equivalent source
// R22: Without management, next page variables still provided
// R23: Registers 16 bits, unused bits read zero
`ifndef ANR_DEFINES_SVH
`define ANR_DEFINES_SVH

`define ANR_OFF_CTL 5'h00
`define ANR_OFF_STS 5'h01
`define ANR_OFF_ADV 5'h04
`define ANR_OFF_LPA 5'h05
`define ANR_OFF_EXP 5'h06
`define ANR_OFF_NPT 5'h07

`define ANR_CTL_SPEED 13
`define ANR_CTL_ANEN 12
`define ANR_CTL_RESTART 9
`define ANR_CTL_DUPLEX 8

`define ANR_STS_TECH_HI 15
`define ANR_STS_TECH_LO 11
`define ANR_STS_COMPLETE 5
`define ANR_STS_RFAULT 4
`define ANR_STS_ANABLE 3

`define ANR_ADV_ACK 14
`define ANR_ADV_TECH_HI 9
`define ANR_ADV_TECH_LO 5
`define ANR_ADV_SEL_HI 4

`define ANR_EXP_LP_AN 0
`define ANR_EXP_PAGE 1
`define ANR_EXP_NP 2
`define ANR_EXP_LP_NP 3
`define ANR_EXP_PDF 4

`define ANR_NPT_RESET 16'h2001
`define ANR_FLAG_CNT 3

`endif

//--- verilog/anr_pkg.sv
// Types shared by the negotiation register bank.
// Assumes the defines header is compiled alongside.
package anr_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } anr_mgmt_req_t;

    typedef struct packed {
        logic ability;
        logic complete;
        logic page_rx;
        logic [15:0] lp_word;
        logic lp_an_able;
        logic lp_np_able;
        logic rfault;
        logic wait_expired;
        logic page_taken;
        logic res_speed;
        logic res_duplex;
    } anr_neg_in_t;

    typedef struct packed {
        logic an_en;
        logic speed;
        logic duplex;
        logic restart;
        logic restart_req;
        logic adv_init;
        logic [15:0] adv;
        logic [15:0] np_tx;
        logic np_loaded;
        logic [15:0] lp;
        logic [15:0] rdata;
        logic rvalid;
        logic cfg_speed;
        logic cfg_duplex;
    } anr_state_t;

    typedef struct packed {
        logic flag;
    } anr_sticky_t;

endpackage : anr_pkg

//--- verilog/anr_sticky.sv
// Sticky event flag; a set in the clearing cycle wins.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module anr_sticky (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event and clear
    input wire logic set,
    input wire logic clr,
    // Flag
    output logic flag_r
);
    anr_pkg::anr_sticky_t st_r;
    anr_pkg::anr_sticky_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.flag = 1'b0;
        end
        if (set) begin
            st_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag_r = st_r.flag;

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // R13
        set |=> flag_r) else $error("sticky flag lost its set");
endmodule : anr_sticky
`default_nettype wire

//--- verilog/anr_regs.sv
// Negotiation management register bank with clear-on-read flags.
// Assumes requests and negotiation inputs are on clk; pd_ready is
// resynchronised here since link monitors may run elsewhere.
`timescale 1ns/100ps
`default_nettype none
`include "anr_defines.svh"
module anr_regs #(
    parameter int PD_CNT = 3,
    parameter bit HAS_MGMT = 1'b1,
    parameter bit NP_SUPPORT = 1'b1,
    parameter bit AN_EN_RESET = 1'b1,
    parameter logic [4:0] SELECTOR = 5'h01
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Management access
    input wire anr_pkg::anr_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata_r,
    output logic mgmt_rvalid_r,
    // Negotiation logic status
    input wire anr_pkg::anr_neg_in_t neg_in,
    input wire logic [4:0] tech_ability,
    input wire logic [PD_CNT-1:0] pd_ready,
    // Equivalents used when no management exists
    input wire logic [15:0] adv_ext,
    input wire logic [15:0] np_ext_word,
    input wire logic np_ext_load,
    // Controls to negotiation logic
    output logic an_enable_r,
    output logic restart_req_r,
    output logic [15:0] adv_ability_r,
    output logic [15:0] np_tx_word_r,
    output logic np_loaded_r,
    output logic np_able_r,
    output logic lp_np_able_r,
    output logic cfg_speed_r,
    output logic cfg_duplex_r
);
    anr_pkg::anr_state_t st_r;
    anr_pkg::anr_state_t st_nxt;
    logic [PD_CNT-1:0] pd_meta_r;
    logic [PD_CNT-1:0] pd_sync_r;
    logic [`ANR_FLAG_CNT-1:0] flag_set;
    logic [`ANR_FLAG_CNT-1:0] flag_clr;
    logic [`ANR_FLAG_CNT-1:0] flag_r;
    logic np_able_q;
    logic lp_np_q;
    logic lp_an_q;
    logic rd_ctl, wr_ctl, rd_sts, rd_exp, wr_exp;
    logic wr_adv, wr_npt, mgmt_rd, mgmt_wr;
    logic complete_bit;
    logic pd_fault_now;

    localparam int F_RFAULT = 0;
    localparam int F_PAGE = 1;
    localparam int F_PDF = 2;

    // Address match, used by every strobe decode; the read mux cases on the address
    function automatic logic at_off(input logic [4:0] addr, input logic [4:0] off);
        at_off = (addr == off);
    endfunction : at_off

    // Number of monitors reporting ready
    function automatic int ready_count(input logic [PD_CNT-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < PD_CNT; i++) begin
            n = n + int'(v[i]);
        end
        ready_count = n;
    endfunction : ready_count

    // R21: without management every request is ignored
    assign mgmt_rd = HAS_MGMT && mgmt_req.rd;
    assign mgmt_wr = HAS_MGMT && mgmt_req.wr;
    assign rd_ctl = mgmt_rd && at_off(mgmt_req.addr, `ANR_OFF_CTL);
    assign wr_ctl = mgmt_wr && at_off(mgmt_req.addr, `ANR_OFF_CTL);
    assign rd_sts = mgmt_rd && at_off(mgmt_req.addr, `ANR_OFF_STS);
    assign rd_exp = mgmt_rd && at_off(mgmt_req.addr, `ANR_OFF_EXP);
    assign wr_exp = mgmt_wr && at_off(mgmt_req.addr, `ANR_OFF_EXP);
    assign wr_adv = mgmt_wr && at_off(mgmt_req.addr, `ANR_OFF_ADV);
    assign wr_npt = mgmt_wr && at_off(mgmt_req.addr, `ANR_OFF_NPT);

    // Link monitors may sit on other clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_meta_r <= '0;
            pd_sync_r <= '0;
        end else begin
            pd_meta_r <= pd_ready;
            pd_sync_r <= pd_meta_r;
        end
    end

    // R17: fault when zero or several monitors ready
    assign pd_fault_now = neg_in.wait_expired && (ready_count(pd_sync_r) != 1);

    // R08: remote fault held until status read
    assign flag_set[F_RFAULT] = neg_in.rfault;
    assign flag_clr[F_RFAULT] = rd_sts;
    // R13: new code word stored
    assign flag_set[F_PAGE] = neg_in.page_rx;
    // R14: cleared by expansion read
    assign flag_clr[F_PAGE] = rd_exp;
    assign flag_set[F_PDF] = pd_fault_now;
    // R18: cleared by expansion read
    assign flag_clr[F_PDF] = rd_exp;

    for (genvar g = 0; g < `ANR_FLAG_CNT; g++) begin : g_flag
        anr_sticky u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .set(flag_set[g]),
            .clr(flag_clr[g]),
            .flag_r(flag_r[g])
        );
    end

    // R15 R16 R12: capability levels, registered for clean outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            np_able_q <= 1'b0;
            lp_np_q <= 1'b0;
            lp_an_q <= 1'b0;
        end else begin
            np_able_q <= NP_SUPPORT;
            lp_np_q <= neg_in.lp_np_able;
            lp_an_q <= neg_in.lp_an_able;
        end
    end

    // R06 R07: complete only when enabled and able
    assign complete_bit = st_r.an_en && neg_in.ability && neg_in.complete;

    always_comb begin
        logic [15:0] rd_val;
        rd_val = '0;
        st_nxt = st_r;
        st_nxt.restart_req = 1'b0;

        // R09: abilities caught once, the cycle after reset release
        if (!st_r.adv_init) begin
            st_nxt.adv_init = 1'b1;
            if (HAS_MGMT) begin
                st_nxt.adv[`ANR_ADV_TECH_HI:`ANR_ADV_TECH_LO] = tech_ability;
            end else begin
                // R21: equivalent advertised vector
                st_nxt.adv = adv_ext;
            end
        end

        if (wr_ctl) begin
            st_nxt.an_en = mgmt_req.wdata[`ANR_CTL_ANEN];
            st_nxt.speed = mgmt_req.wdata[`ANR_CTL_SPEED];
            st_nxt.duplex = mgmt_req.wdata[`ANR_CTL_DUPLEX];
        end

        // R04: completion clears the pending restart
        if (st_r.restart && neg_in.complete) begin
            st_nxt.restart = 1'b0;
        end
        // R05: only a one acts; zero leaves the bit alone
        if (wr_ctl && mgmt_req.wdata[`ANR_CTL_RESTART]) begin
            st_nxt.restart = 1'b1;
            st_nxt.restart_req = 1'b1;
        end

        // Ack stays zero with management; the arbiter owns it on the wire
        if (wr_adv) begin
            st_nxt.adv = mgmt_req.wdata;
            st_nxt.adv[`ANR_ADV_ACK] = 1'b0;
        end

        // R10: partner word mirrored on each reception
        if (neg_in.page_rx) begin
            st_nxt.lp = neg_in.lp_word;
        end

        // Page taken by arbiter; a new write in the same cycle wins
        if (neg_in.page_taken) begin
            st_nxt.np_loaded = 1'b0;
        end
        // R20: any write marks a fresh page
        if (NP_SUPPORT && wr_npt) begin
            st_nxt.np_tx = mgmt_req.wdata;
            st_nxt.np_loaded = 1'b1;
        end
        // R22: equivalent page source without management
        if (NP_SUPPORT && !HAS_MGMT && np_ext_load) begin
            st_nxt.np_tx = np_ext_word;
            st_nxt.np_loaded = 1'b1;
        end

        // R02: manual settings ignored while negotiating
        if (st_r.an_en) begin
            st_nxt.cfg_speed = neg_in.res_speed;
            st_nxt.cfg_duplex = neg_in.res_duplex;
        end else begin
            st_nxt.cfg_speed = st_r.speed;
            st_nxt.cfg_duplex = st_r.duplex;
        end

        // R01 R23: 16-bit map, unmapped and reserved bits read zero
        unique case (mgmt_req.addr)
            `ANR_OFF_CTL: begin
                rd_val[`ANR_CTL_SPEED] = st_r.speed;
                rd_val[`ANR_CTL_ANEN] = st_r.an_en;
                // R03: reads one while a restart is pending
                rd_val[`ANR_CTL_RESTART] = st_r.restart;
                rd_val[`ANR_CTL_DUPLEX] = st_r.duplex;
            end
            `ANR_OFF_STS: begin
                rd_val[`ANR_STS_TECH_HI:`ANR_STS_TECH_LO] = tech_ability;
                rd_val[`ANR_STS_COMPLETE] = complete_bit;
                rd_val[`ANR_STS_RFAULT] = flag_r[F_RFAULT];
                rd_val[`ANR_STS_ANABLE] = neg_in.ability;
            end
            `ANR_OFF_ADV: begin
                rd_val = st_r.adv;
            end
            `ANR_OFF_LPA: begin
                rd_val = st_r.lp;
            end
            // R11: value only, writes have no path here
            `ANR_OFF_EXP: begin
                rd_val[`ANR_EXP_LP_AN] = lp_an_q;
                rd_val[`ANR_EXP_PAGE] = flag_r[F_PAGE];
                rd_val[`ANR_EXP_NP] = np_able_q;
                rd_val[`ANR_EXP_LP_NP] = lp_np_q;
                rd_val[`ANR_EXP_PDF] = flag_r[F_PDF];
            end
            `ANR_OFF_NPT: begin
                if (NP_SUPPORT) begin
                    rd_val = st_r.np_tx;
                end
            end
            default: begin
                rd_val = '0;
            end
        endcase

        st_nxt.rvalid = mgmt_rd;
        if (mgmt_rd) begin
            st_nxt.rdata = rd_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.an_en <= AN_EN_RESET;
            // R09: selector defined, ack zero at power-on
            st_r.adv[`ANR_ADV_SEL_HI:0] <= SELECTOR;
            // R19: next page default
            st_r.np_tx <= `ANR_NPT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mgmt_rdata_r = st_r.rdata;
    assign mgmt_rvalid_r = st_r.rvalid;
    assign an_enable_r = st_r.an_en;
    assign restart_req_r = st_r.restart_req;
    assign adv_ability_r = st_r.adv;
    assign np_tx_word_r = st_r.np_tx;
    assign np_loaded_r = st_r.np_loaded;
    assign np_able_r = np_able_q;
    assign lp_np_able_r = lp_np_q;
    assign cfg_speed_r = st_r.cfg_speed;
    assign cfg_duplex_r = st_r.cfg_duplex;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_restart_reads_one: assert property ( // R03
        st_r.restart && !neg_in.complete && rd_ctl |=> mgmt_rdata_r[`ANR_CTL_RESTART])
        else $error("pending restart read as zero");

    a_restart_start: assert property ( // R04
        wr_ctl && mgmt_req.wdata[`ANR_CTL_RESTART] |=> st_r.restart && restart_req_r
        ##1 (!restart_req_r || $past(wr_ctl && mgmt_req.wdata[`ANR_CTL_RESTART])))
        else $error("restart write did not start negotiation");

    a_restart_zero_wr: assert property ( // R05
        st_r.restart && !neg_in.complete && wr_ctl && !mgmt_req.wdata[`ANR_CTL_RESTART]
        |=> st_r.restart)
        else $error("zero write cleared restart");

    a_manual_ignored: assert property ( // R02
        st_r.an_en && wr_ctl |=> cfg_speed_r == $past(neg_in.res_speed))
        else $error("manual speed used while negotiating");

    a_complete_zero: assert property ( // R06
        rd_sts && !st_r.an_en |=> !mgmt_rdata_r[`ANR_STS_COMPLETE])
        else $error("complete bit set while disabled");

    a_rfault_hold: assert property ( // R08
        flag_r[F_RFAULT] && !rd_sts |=> flag_r[F_RFAULT])
        else $error("remote fault dropped without status read");

    a_page_clear: assert property ( // R14
        rd_exp && !neg_in.page_rx |=> !flag_r[F_PAGE])
        else $error("page received not cleared by read");

    a_exp_wr_noeffect: assert property ( // R11
        wr_exp && !mgmt_rd && flag_r[F_PDF] |=> flag_r[F_PDF])
        else $error("expansion write changed a flag");

    a_pd_fault_set: assert property ( // R17
        neg_in.wait_expired && ready_count(pd_sync_r) != 1 |=> flag_r[F_PDF])
        else $error("parallel detect fault missed");

    a_lp_mirror: assert property ( // R10
        neg_in.page_rx |=> st_r.lp == $past(neg_in.lp_word) && flag_r[F_PAGE])
        else $error("partner word not mirrored");

    a_np_loaded: assert property ( // R20
        NP_SUPPORT && wr_npt |=> np_loaded_r && np_tx_word_r == $past(mgmt_req.wdata))
        else $error("next page write did not load");

    a_lp_read_only: assert property ( // R10
        mgmt_wr && at_off(mgmt_req.addr, `ANR_OFF_LPA) && !neg_in.page_rx |=> $stable(st_r.lp))
        else $error("partner ability changed by a write");

    a_complete_set: assert property ( // R07
        rd_sts && st_r.an_en && neg_in.ability && neg_in.complete
        |=> mgmt_rdata_r[`ANR_STS_COMPLETE])
        else $error("complete bit not set after success");

    a_rfault_clear: assert property ( // R08
        rd_sts && !neg_in.rfault |=> !flag_r[F_RFAULT])
        else $error("remote fault kept after status read");

    a_pd_clear: assert property ( // R18
        rd_exp && !pd_fault_now |=> !flag_r[F_PDF])
        else $error("parallel detect fault kept after read");

    a_manual_used: assert property ( // R02
        !st_r.an_en |=> cfg_speed_r == $past(st_r.speed) && cfg_duplex_r == $past(st_r.duplex))
        else $error("manual setting not applied while disabled");

endmodule : anr_regs
`default_nettype wire

//--- testbench/anr_station.sv
// Management station model driving one-cycle read and write strobes.
// Assumes read data is registered at the taking edge itself.
`timescale 1ns/100ps
`default_nettype none
module anr_station (
    // Clock
    input wire logic clk,
    // Management bus
    output var anr_pkg::anr_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata_r,
    input wire logic mgmt_rvalid_r
);
    initial mgmt_req = '0;

    // Strobe stands for exactly one taking edge, answer taken just after that same edge
    task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] data,
                          output logic [15:0] rdata, output logic rv);
        @(posedge clk);
        mgmt_req <= {~wr, wr, addr, data};
        @(posedge clk);
        mgmt_req <= '0;
        #1;
        rdata = mgmt_rdata_r;
        rv = mgmt_rvalid_r;
    endtask : access
endmodule : anr_station
`default_nettype wire

//--- testbench/autoneg_mgmt_registers_tb.sv
// Self-checking bench for the negotiation register bank.
// Assumes the managed bank is the only device answering the management strobes.
`timescale 1ns/100ps
`default_nettype none
`include "anr_defines.svh"
module autoneg_mgmt_registers_tb;
    // Enough for all tests with a wide margin
    localparam int LIMIT = 4000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    anr_pkg::anr_mgmt_req_t mgmt_req;
    anr_pkg::anr_neg_in_t neg = '0;
    logic [4:0] tech = 5'h00;
    logic [2:0] pd = 3'h0;
    logic [15:0] rdata, adv_q, np_q, got;
    logic rvalid, an_en, restart_q, np_loaded, np_able, lp_np_able, cfg_speed, cfg_duplex;
    logic rv;
    logic [15:0] adv_e, adv2, np2;
    logic [15:0] np_e = 16'h0000;
    logic np_ld = 1'b0;
    logic npl2;
    logic [31:0] seed = 32'hBA1C514E;
    logic [31:0] r;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    anr_station u_sta (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata_r(rdata),
                       .mgmt_rvalid_r(rvalid));

    anr_regs DUT (.clk(clk), .rst_n(rst_n), .mgmt_req(mgmt_req), .mgmt_rdata_r(rdata),
        .mgmt_rvalid_r(rvalid), .neg_in(neg), .tech_ability(tech), .pd_ready(pd),
        .adv_ext(16'h0000), .np_ext_word(16'h0000), .np_ext_load(1'b0),
        .an_enable_r(an_en), .restart_req_r(restart_q), .adv_ability_r(adv_q),
        .np_tx_word_r(np_q), .np_loaded_r(np_loaded), .np_able_r(np_able),
        .lp_np_able_r(lp_np_able), .cfg_speed_r(cfg_speed), .cfg_duplex_r(cfg_duplex));

    // Same bank without management: equivalents feed it
    anr_regs #(.HAS_MGMT(1'b0)) DUT_nom (.clk(clk), .rst_n(rst_n), .mgmt_req(mgmt_req),
        .mgmt_rdata_r(), .mgmt_rvalid_r(), .neg_in(neg), .tech_ability(tech), .pd_ready(pd),
        .adv_ext(adv_e), .np_ext_word(np_e), .np_ext_load(np_ld), .an_enable_r(),
        .restart_req_r(), .adv_ability_r(adv2), .np_tx_word_r(np2), .np_loaded_r(npl2),
        .np_able_r(), .lp_np_able_r(), .cfg_speed_r(), .cfg_duplex_r());

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic pd_fault(input logic [2:0] p);
        return $countones(p) != 1;
    endfunction : pd_fault

    function automatic logic [15:0] expn(input logic lpan, input logic page, input logic lpnp,
                                         input logic pdf);
        return {11'h000, pdf, lpnp, 1'b1, page, lpan};
    endfunction : expn

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [4:0] a);
        u_sta.access(1'b0, a, 16'h0000, got, rv);
        check({15'h0000, rv}, 16'h0001, "read valid"); // read answered
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_sta.access(1'b1, a, d, got, rv);
        check({15'h0000, rv}, 16'h0000, "write valid"); // write unanswered
    endtask : wr

    task automatic pulse_wait();
        @(posedge clk);
        neg.wait_expired <= 1'b1;
        @(posedge clk);
        neg.wait_expired <= 1'b0;
    endtask : pulse_wait

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        r = xs();
        tech = r[4:0];
        adv_e = r[31:16];
        neg.ability = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`ANR_OFF_CTL); check(got, 16'h1000, "control reset"); // control reset
        check({15'h0, an_en}, 16'h0001, "enable out"); // enable at reset
        check(adv2, adv_e, "equivalent adv"); // vector from equivalent
        rd(`ANR_OFF_ADV); check(got, {6'h00, tech, 5'h01}, "adv reset"); // advertisement reset
        rd(`ANR_OFF_NPT); check(got, 16'h2001, "next page reset"); // next page
        rd(5'h02); check(got, 16'h0000, "unmapped"); // unmapped zero
        rd(`ANR_OFF_EXP); check(got, expn(0, 0, 0, 0), "exp reset"); // local next page
        $display("test reset values done");

        r = xs();
        wr(`ANR_OFF_ADV, r[15:0]);
        rd(`ANR_OFF_ADV); check(got, r[15:0] & 16'hBFFF, "adv write"); // ack zero
        check(adv_q, r[15:0] & 16'hBFFF, "adv out"); // advertisement present
        wr(`ANR_OFF_LPA, r[31:16]);
        wr(`ANR_OFF_EXP, r[31:16]);
        rd(`ANR_OFF_LPA); check(got, 16'h0000, "lp write"); // read only
        rd(`ANR_OFF_EXP); check(got, expn(0, 0, 0, 0), "exp write"); // read only
        $display("test access kinds done");

        wr(`ANR_OFF_CTL, 16'h3300); check({15'h0, restart_q}, 16'h0001, "restart"); // restart pulse
        rd(`ANR_OFF_CTL); check(got, 16'h3300, "restart pending"); // pending reads one
        wr(`ANR_OFF_CTL, 16'h3100);
        rd(`ANR_OFF_CTL); check(got, 16'h3300, "restart zero"); // zero ignored
        check({14'h0, cfg_speed, cfg_duplex}, 16'h0000, "cfg auto"); // manual ignored
        @(posedge clk);
        neg.complete <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`ANR_OFF_CTL); check(got, 16'h3100, "restart clear"); // completion clears
        rd(`ANR_OFF_STS); check(got & 16'hF820, {tech, 11'h020}, "complete"); // complete set
        wr(`ANR_OFF_CTL, 16'h2100);
        repeat (2) @(posedge clk);
        #1;
        check({14'h0, cfg_speed, cfg_duplex}, 16'h0003, "cfg manual"); // manual used
        check({15'h0, an_en}, 16'h0000, "enable off"); // enable cleared
        rd(`ANR_OFF_STS); check(got & 16'h0020, 16'h0000, "complete off"); // disabled zero
        $display("test control done");

        @(posedge clk);
        neg.rfault <= 1'b1;
        @(posedge clk);
        neg.rfault <= 1'b0;
        repeat (3) @(posedge clk);
        rd(`ANR_OFF_STS); check(got & 16'h0010, 16'h0010, "rfault set"); // sticky fault
        rd(`ANR_OFF_STS); check(got & 16'h0010, 16'h0000, "rfault clr"); // read clears
        $display("test remote fault done");

        r = xs();
        @(posedge clk);
        neg.lp_word <= r[15:0];
        neg.page_rx <= 1'b1;
        neg.lp_an_able <= 1'b1;
        neg.lp_np_able <= 1'b1;
        @(posedge clk);
        neg.page_rx <= 1'b0;
        wr(`ANR_OFF_LPA, ~r[15:0]);
        rd(`ANR_OFF_LPA); check(got, r[15:0], "lp word"); // mirrors word
        rd(`ANR_OFF_EXP); check(got, expn(1, 1, 1, 0), "page set"); // page received
        check(got & 16'h0001, 16'h0001, "lp able"); // partner able
        rd(`ANR_OFF_EXP); check(got, expn(1, 0, 1, 0), "page clr"); // read clears
        check({14'h0, np_able, lp_np_able}, 16'h0003, "np able"); // partner next page
        $display("test page receive done");

        for (int p = 0; p < 8; p++) begin
            @(posedge clk);
            pd <= p[2:0];
            repeat (4) @(posedge clk);
            pulse_wait();
            wr(`ANR_OFF_EXP, 16'hFFFF); // write ignored
            rd(`ANR_OFF_EXP); check(got, expn(1, 0, 1, pd_fault(p[2:0])), "pd"); // fault
        end
        rd(`ANR_OFF_EXP); check(got, expn(1, 0, 1, 0), "pd clr"); // read clears
        $display("test parallel detect done");

        r = xs();
        wr(`ANR_OFF_NPT, r[15:0]); check({15'h0, np_loaded}, 16'h0001, "np load"); // loaded
        rd(`ANR_OFF_NPT); check(got, r[15:0], "np word"); // next page present
        check(np_q, r[15:0], "np out"); // word out
        check({15'h0, npl2}, 16'h0000, "np no mgmt"); // requests ignored
        @(posedge clk);
        neg.page_taken <= 1'b1;
        @(posedge clk);
        neg.page_taken <= 1'b0;
        #1;
        check({15'h0, np_loaded}, 16'h0000, "np taken"); // loaded cleared
        @(posedge clk);
        np_e <= r[31:16];
        np_ld <= 1'b1;
        @(posedge clk);
        np_ld <= 1'b0;
        #1;
        check(np2, r[31:16], "np equivalent"); // page source
        check({15'h0, npl2}, 16'h0001, "np ext load"); // loaded equivalent
        $display("test next page done");
        end_of_test();
    end
endmodule : autoneg_mgmt_registers_tb
`default_nettype wire
